// *** rtl/wdt_core.sv ***
/*
 * Watchdog with period select, software enable and sleep entry, on an APB slave.
 * Assumes a synchronous environment on pclk and a CPU that issues sleep by command.
 */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "wdt_defines.svh"

module wdt_core
   import wdt_pkg::*;
#(
   parameter int unsigned PORT_W = 8,
   parameter int unsigned LF_DIV = `LFOSC_DIV_CYCLES
) (
   // APB slave.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration and CPU side.
   input wire logic config_watchdog_enable,
   input wire logic sleep_cmd,
   input wire logic clear_cmd,
   input wire logic wake_event,
   // Port pins as driven by the core.
   input wire logic [PORT_W-1:0] port_out_core,
   input wire logic [PORT_W-1:0] port_oe_core,
   // Outputs.
   output logic [PORT_W-1:0] port_out,
   output logic [PORT_W-1:0] port_oe,
   output logic osc_driver_en,
   output logic sleeping,
   output logic internal_reset,
   output logic external_reset_pin_oe,
   output logic irq
);
   // Refuse an empty port bank when the design is elaborated.
   if (PORT_W < 1) begin : g_port_w_check
      $error("wdt_core: PORT_W must be at least 1");
   end

   // Expiry count for a period code: 2 to the power of 5 plus the code, in LF ticks.
   function automatic logic [16:0] period_ticks(input logic [3:0] code);
      logic [4:0] sh;
      sh = 5'(`PRESCALE_BASE_LOG2) + {1'b0, code};
      period_ticks = 17'h0_0001 << sh;
   endfunction

   function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
      is_addr = (a == off);
   endfunction

   typedef struct packed {
      wdt_ctrl_t ctrl;
      logic [7:0] option_control;
      sys_flags_t flags;
      logic [`IRQ_WIDTH-1:0] irq_status;
      logic [`IRQ_WIDTH-1:0] irq_mask;
      pwr_state_t pstate;
      logic [16:0] count;
      logic [PORT_W-1:0] port_out;
      logic [PORT_W-1:0] port_oe;
      logic osc_driver_en;
      logic internal_reset;
      logic ext_pin_oe;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } core_state_t;

   core_state_t s, next_s;
   logic lf_tick;
   logic wdt_on;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic go_sleep;
   logic do_clear;
   logic do_wake;
   logic expired;
   logic [`IRQ_WIDTH-1:0] irq_set;
   logic [31:0] rdata;

   wdt_lf_tick #(
      .DIV(LF_DIV)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(lf_tick)
   );

   // Effective enable: config bit overrides the soft bit.
   assign wdt_on = config_watchdog_enable | s.ctrl.soft_watchdog_enable;

   // APB decode; the slave answers in the second access cycle, one wait state.
   assign wr_acc = psel & penable & pwrite & ~s.pready;
   assign rd_acc = psel & penable & ~pwrite & ~s.pready;
   assign mapped = is_addr(paddr, `OFF_WATCHDOG_CONTROL) | is_addr(paddr, `OFF_OPTION_CONTROL)
      | is_addr(paddr, `OFF_IRQ_STATUS) | is_addr(paddr, `OFF_IRQ_MASK)
      | is_addr(paddr, `OFF_SYS_STATUS) | is_addr(paddr, `OFF_COMMAND);

   // Sleep is reached only through the sleep command, pin or register.
   assign go_sleep = (s.pstate != st_sleep) & (sleep_cmd | (wr_acc
      & is_addr(paddr, `OFF_COMMAND) & pwdata[`CMD_SLEEP_BIT]));
   assign do_clear = clear_cmd | (wr_acc & is_addr(paddr, `OFF_COMMAND)
      & pwdata[`CMD_CLEAR_BIT]);
   assign do_wake = (s.pstate == st_sleep) & (wake_event | (wr_acc
      & is_addr(paddr, `OFF_COMMAND) & pwdata[`CMD_WAKE_BIT]));
   assign expired = wdt_on & lf_tick & (s.count + 17'h0_0001 >= period_ticks(s.ctrl.period_select));

   assign irq_set = {go_sleep, expired};

   // Read multiplexer; reserved bits read zero.
   always_comb begin
      rdata = 32'h0000_0000;
      if (is_addr(paddr, `OFF_WATCHDOG_CONTROL)) begin
         rdata[4:0] = s.ctrl;
      end else if (is_addr(paddr, `OFF_OPTION_CONTROL)) begin
         rdata[7:0] = s.option_control;
      end else if (is_addr(paddr, `OFF_IRQ_STATUS)) begin
         rdata[`IRQ_WIDTH-1:0] = s.irq_status;
      end else if (is_addr(paddr, `OFF_IRQ_MASK)) begin
         rdata[`IRQ_WIDTH-1:0] = s.irq_mask;
      end else if (is_addr(paddr, `OFF_SYS_STATUS)) begin
         rdata[`PD_BIT] = s.flags.power_down_flag;
         rdata[`TO_BIT] = s.flags.expiry_flag;
         rdata[2] = (s.pstate == st_sleep);
         rdata[3] = wdt_on;
      end
   end

   // Next-state logic for the whole block.
   always_comb begin
      next_s = s;
      next_s.pready = psel & penable & ~s.pready;
      next_s.pslverr = psel & penable & ~s.pready & ~mapped;
      next_s.internal_reset = 1'b0;
      next_s.ext_pin_oe = 1'b0; // The block never pulls the external reset pin.
      if (rd_acc) begin
         next_s.prdata = rdata;
      end

      // Register writes.
      if (wr_acc && is_addr(paddr, `OFF_WATCHDOG_CONTROL)) begin
         next_s.ctrl = pwdata[4:0]; // Upper bits dropped.
      end
      if (wr_acc && is_addr(paddr, `OFF_OPTION_CONTROL)) begin
         next_s.option_control = pwdata[7:0];
      end
      if (wr_acc && is_addr(paddr, `OFF_IRQ_MASK)) begin
         next_s.irq_mask = pwdata[`IRQ_WIDTH-1:0];
      end
      // Write-one-to-clear; a same-cycle event wins over the clear.
      if (wr_acc && is_addr(paddr, `OFF_IRQ_STATUS)) begin
         next_s.irq_status = s.irq_status & ~pwdata[`IRQ_WIDTH-1:0];
      end
      next_s.irq_status = next_s.irq_status | irq_set;

      // Counter: held clear while off, restarted by clear, wake or sleep entry.
      if (!wdt_on || do_clear || do_wake) begin
         next_s.count = '0;
      end else if (go_sleep) begin
         next_s.count = '0; // Cleared, but still enabled so it keeps counting.
      end else if (lf_tick) begin
         next_s.count = expired ? 17'h0_0000 : s.count + 17'h0_0001;
      end

      // Power state sequencing.
      unique case (s.pstate)
         st_run, st_off: begin
            next_s.pstate = wdt_on ? st_run : st_off;
            next_s.port_out = port_out_core;
            next_s.port_oe = port_oe_core;
            if (go_sleep) begin
               next_s.pstate = st_sleep;
               next_s.flags.power_down_flag = 1'b0;
               next_s.flags.expiry_flag = 1'b1;
               next_s.osc_driver_en = 1'b0;
            end
         end
         st_sleep: begin
            // Ports frozen at their pre-sleep drive and enable.
            if (do_wake || expired) begin
               next_s.pstate = wdt_on ? st_run : st_off;
               next_s.osc_driver_en = 1'b1;
            end
         end
         default: begin
            next_s.pstate = st_off;
         end
      endcase

      // Expiry: clear expiry flag and reset internally outside sleep.
      if (expired) begin
         next_s.flags.expiry_flag = 1'b0;
         if (s.pstate != st_sleep) begin
            next_s.internal_reset = 1'b1; // Pin stays released.
            // An expiry reset is a reset type too, so control and option reload.
            next_s.ctrl = wdt_ctrl_t'(5'(`WATCHDOG_CONTROL_RST));
            next_s.option_control = `OPTION_CONTROL_RST;
         end
      end

      next_s.irq = |(next_s.irq_status & next_s.irq_mask);
   end

   // Reset leaves the flags set (power-up) and the control at its default.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.ctrl <= wdt_ctrl_t'(5'(`WATCHDOG_CONTROL_RST));
         s.option_control <= `OPTION_CONTROL_RST;
         s.flags <= 2'b11;
         s.pstate <= st_off;
         s.osc_driver_en <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign port_out = s.port_out;
   assign port_oe = s.port_oe;
   assign osc_driver_en = s.osc_driver_en;
   assign sleeping = s.pstate[2];
   assign internal_reset = s.internal_reset;
   assign external_reset_pin_oe = s.ext_pin_oe; // Never driven.
   assign irq = s.irq;
endmodule

// *** rtl/wdt_defines.svh ***
/*
 * Offsets, field positions, reset values and timing counts for the watchdog block.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// Register byte offsets on the APB.
`define OFF_WATCHDOG_CONTROL 12'h000
`define OFF_OPTION_CONTROL 12'h004
`define OFF_IRQ_STATUS 12'h008
`define OFF_IRQ_MASK 12'h00C
`define OFF_SYS_STATUS 12'h010
`define OFF_COMMAND 12'h014

// Field positions of the watchdog control register.
`define SOFT_EN_BIT 0
`define PSEL_LSB 1
`define PSEL_MSB 4
`define CTRL_IMPL_MASK 8'h1F

// Reset values.
`define WATCHDOG_CONTROL_RST 8'h08
`define OPTION_CONTROL_RST 8'hFF
`define PSEL_RST 4'h4

// Status flag bits: power-down flag bit 0, expiry flag bit 1.
`define PD_BIT 0
`define TO_BIT 1

// Interrupt status bits.
`define IRQ_EXPIRY 0
`define IRQ_SLEEP 1
`define IRQ_WIDTH 2

// Command register bits.
`define CMD_SLEEP_BIT 0
`define CMD_CLEAR_BIT 1
`define CMD_WAKE_BIT 2

// Largest legal period-select code and shortest prescale exponent (1:32).
`define PSEL_MAX 4'hB
`define PRESCALE_BASE_LOG2 5

// Low-frequency oscillator at 31 kHz against the 100 MHz bus clock.
`define LFOSC_HZ 31000
`define PCLK_HZ 100000000
`define LFOSC_DIV_CYCLES (`PCLK_HZ / `LFOSC_HZ)

`endif

// *** rtl/wdt_pkg.sv ***
/*
 * Types shared by the watchdog block.
 * Assumes the defines header is compiled alongside.
 */
package wdt_pkg;
   typedef enum logic [2:0] {
      st_run = 3'b001,
      st_off = 3'b010,
      st_sleep = 3'b100
   } pwr_state_t;

   typedef struct packed {
      logic [3:0] period_select;
      logic soft_watchdog_enable;
   } wdt_ctrl_t;

   typedef struct packed {
      logic power_down_flag;
      logic expiry_flag;
   } sys_flags_t;
endpackage

// *** rtl/wdt_lf_tick.sv ***
/*
 * Tick generator that stands in for the low-frequency internal oscillator.
 * Assumes pclk runs continuously, also while the core is asleep.
 */
`timescale 1ns/100ps
`include "wdt_defines.svh"

module wdt_lf_tick #(
   parameter int unsigned DIV = `LFOSC_DIV_CYCLES
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Tick out.
   output logic tick
);
   // A divider below two could never return to zero between pulses.
   if (DIV < 2) begin : g_div_check
      $error("wdt_lf_tick: DIV must be at least 2");
   end

   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } tick_state_t;

   tick_state_t s, next_s;

   // One pulse every DIV cycles.
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == DIV - 1) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule

// *** sim/wdt_core_monitor.sv ***
/* Port checker for the watchdog core.
   Assumes it is bound into wdt_core and sees only its ports. */
`timescale 1ns/100ps
`include "wdt_defines.svh"
module wdt_core_monitor #(
   parameter int unsigned PORT_W = 8
) (
   // Bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Core and pins.
   input wire logic config_watchdog_enable,
   input wire logic sleep_cmd,
   input wire logic internal_reset,
   input wire logic [PORT_W-1:0] port_out,
   input wire logic [PORT_W-1:0] port_oe,
   input wire logic osc_driver_en,
   input wire logic sleeping,
   input wire logic external_reset_pin_oe
);
   logic soft_en;
   logic next_soft_en;
   logic cmd_sleep_wr;
   // A write of the sleep bit to the command register is the other way into sleep.
   assign cmd_sleep_wr = psel && penable && pwrite && (paddr == `OFF_COMMAND)
      && pwdata[`CMD_SLEEP_BIT];
   // Mirror of the soft enable; an internal reset drops it like the register.
   always_comb begin
      next_soft_en = soft_en;
      if (psel && penable && pready && pwrite && paddr == `OFF_WATCHDOG_CONTROL)
         next_soft_en = pwdata[0];
      if (internal_reset)
         next_soft_en = 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         soft_en <= 1'b0;
      else
         soft_en <= next_soft_en;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_enter;
      ##[1:2] sleeping;
   endsequence
   a_pin_released: assert property (external_reset_pin_oe == 1'b0)
      else $error("reset pin driven");
   a_no_sleep_reset: assert property (internal_reset |-> !sleeping)
      else $error("reset while asleep");
   a_sleep_entry: assert property (sleep_cmd |-> s_enter)
      else $error("sleep not entered");
   a_sleep_cause: assert property ($rose(sleeping) |-> $past(sleep_cmd) || $past(cmd_sleep_wr))
      else $error("sleep without command");
   a_osc_stops: assert property (sleeping |-> !osc_driver_en)
      else $error("oscillator on in sleep");
   a_ports_hold: assert property (sleeping && $past(sleeping) |->
      $stable(port_out) && $stable(port_oe))
      else $error("port moved in sleep");
   a_off_quiet: assert property ((!config_watchdog_enable && !soft_en) [*3] |->
      !internal_reset)
      else $error("expiry while disabled");
   a_bus_answer: assert property (psel && penable |-> ##[0:1] pready)
      else $error("bus not answered");
endmodule
bind wdt_core wdt_core_monitor #(.PORT_W(PORT_W)) wdt_core_monitor_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .config_watchdog_enable, .sleep_cmd,
   .internal_reset, .port_out, .port_oe, .osc_driver_en, .sleeping, .external_reset_pin_oe);

// *** sim/wdt_core_tb.sv ***
/* Self-checking bench for wdt_core.
   Assumes a tick divider of 4 so every period the bench waits out fits a short run. */
`timescale 1ns/100ps
`include "wdt_defines.svh"
module wdt_core_tb;
   localparam int DIV = 4;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
   logic cfg = 0, slp = 0, clr = 0, wake = 0, osc, sleeping, irst, irq;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, d;
   logic [7:0] pc = 0, poc = 0, po, poe;
   logic pin_oe;
   logic [15:0] held;
   int n_fail = 0, checks = 0, n;
   time t0;
   wdt_core #(.LF_DIV(DIV)) wdt_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .config_watchdog_enable(cfg), .sleep_cmd(slp),
      .clear_cmd(clr), .wake_event(wake), .port_out_core(pc), .port_oe_core(poc),
      .port_out(po), .port_oe(poe), .osc_driver_en(osc), .sleeping, .internal_reset(irst),
      .external_reset_pin_oe(pin_oe), .irq);
   always #5 pclk = ~pclk;
   // Core drive changes every cycle, so a frozen port shows at once.
   always @(posedge pclk) begin
      pc <= 8'($urandom);
      poc <= 8'($urandom);
   end
   function automatic int per(input int c);
      return (32 << c) * DIV;
   endfunction
   task automatic cmp(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Durations allow one tick of phase slack plus the pipeline.
   task automatic near(input int g, e);
      checks++;
      if (g < e - 8 || g > e + 8) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      cmp(rd, e);
   endtask
   // Clears the watchdog, then counts cycles up to the internal reset.
   task automatic expiry();
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (irst !== 1'b1);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #800us;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      n = $urandom(32'h4f54_20f1);
      repeat (12) @(posedge pclk);
      presetn <= 1; // Held high from here on, sleep included.
      @(posedge pclk);
      rchk(`OFF_WATCHDOG_CONTROL, 32'h0000_0008);
      rchk(`OFF_OPTION_CONTROL, 32'h0000_00ff);
      rchk(`OFF_SYS_STATUS, 32'h0000_0003);
      repeat (6) begin
         d = $urandom;
         d[4:0] = {4'($urandom_range(11, 0)), 1'b0};
         apb(1, `OFF_WATCHDOG_CONTROL, d);
         rchk(`OFF_WATCHDOG_CONTROL, {27'h0, d[4:0]});
         apb(1, `OFF_OPTION_CONTROL, d);
         rchk(`OFF_OPTION_CONTROL, {24'h0, d[7:0]});
      end
      apb(0, 12'h018, 0);
      cmp({rd[31:1], err}, 32'h0000_0001);
      $display("registers done");
      // Forced enable runs despite soft enable 0; expiry reloads the control.
      cfg <= 1;
      for (int i = 0; i < 6; i++) begin
         d = (i < 5) ? i : $urandom_range(6, 5);
         apb(1, `OFF_WATCHDOG_CONTROL, d << 1);
         expiry();
         near(n, per(d));
         rchk(`OFF_WATCHDOG_CONTROL, 32'h0000_0008);
      end
      $display("periods done");
      cfg <= 0;
      apb(1, `OFF_WATCHDOG_CONTROL, 0);
      n = 0;
      repeat (400) begin
         @(posedge pclk);
         if (irst !== 1'b0)
            n++;
      end
      cmp(n, 0);
      apb(1, `OFF_WATCHDOG_CONTROL, 1);
      expiry();
      near(n, per(0));
      cmp(pin_oe, 0);
      $display("soft enable done");
      // Sleep mid-period: the count restarts, so wake-up comes a full period later.
      cfg <= 1;
      apb(1, `OFF_WATCHDOG_CONTROL, 0);
      apb(1, `OFF_IRQ_STATUS, 3);
      apb(1, `OFF_IRQ_MASK, 2);
      @(posedge pclk);
      cmp(irq, 0);
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      repeat (60) @(posedge pclk);
      slp <= 1;
      @(posedge pclk);
      slp <= 0;
      t0 = $time;
      repeat (3) @(posedge pclk);
      cmp(osc, 0);
      held = {po, poe};
      cmp(irq, 1);
      apb(0, `OFF_SYS_STATUS, 0);
      cmp(rd & 3, 2);
      apb(1, `OFF_IRQ_MASK, 0);
      @(posedge pclk);
      cmp(irq, 0);
      apb(1, `OFF_IRQ_STATUS, 2);
      rchk(`OFF_IRQ_STATUS, 0);
      cmp({po, poe}, held);
      while (sleeping !== 1'b0) @(posedge pclk);
      near(($time - t0) / 10, per(0));
      $display("sleep done");
      // Second sleep goes through the command register instead of the pin.
      cfg <= 0;
      apb(1, `OFF_COMMAND, 1);
      repeat (200) @(posedge pclk);
      cmp(sleeping, 1);
      wake <= 1;
      @(posedge pclk);
      wake <= 0;
      repeat (3) @(posedge pclk);
      cmp({sleeping, osc}, 2'b01);
      $display("wake done");
      tally_and_finish();
   end
endmodule
